// ### hdl/hsc_pkg.sv
// package with constants for the humidity sensor command port
package hsc_pkg;
   localparam int        CLK_MHZ         = 200;
   localparam logic [6:0] DEV_ADDR       = 7'h40;
   localparam logic [1:0] MODE_ANALOG    = 2'h0;
   localparam logic [1:0] MODE_PWM       = 2'h1;
   localparam logic [1:0] MODE_PDM       = 2'h2;
   localparam logic [1:0] MODE_I2C       = 2'h3;
   localparam logic [7:0] CMD_T_HOLD     = 8'hE3;
   localparam logic [7:0] CMD_RH_HOLD    = 8'hE5;
   localparam logic [7:0] CMD_T_POLL     = 8'hF3;
   localparam logic [7:0] CMD_RH_POLL    = 8'hF5;
   localparam logic [7:0] CMD_WR_USER    = 8'hE6;
   localparam logic [7:0] CMD_RD_USER    = 8'hE7;
   localparam logic [7:0] CMD_SOFT_RST   = 8'hFE;
   localparam logic [7:0] USER_RESET     = 8'h3A;
   localparam logic [7:0] CRC_POLY       = 8'h31;
   localparam logic [7:0] CRC_INIT       = 8'h00;
   localparam int        STARTUP_MS      = 10;
   localparam int        SOFT_RESET_MS   = 15;
   localparam int        T14_MS          = 34;
   localparam int        T13_MS          = 17;
   localparam int        T11_MS          = 9;
   localparam int        RH12_MS         = 38;
   localparam int        RH11_MS         = 22;
   localparam int        RH8_MS          = 9;
   localparam int        CYC_PER_MS      = CLK_MHZ * 1000;
   localparam int        STARTUP_CYC     = STARTUP_MS * CYC_PER_MS;
   localparam int        SOFT_RESET_CYC  = SOFT_RESET_MS * CYC_PER_MS;
endpackage

// ### hdl/hsc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hsc_sync #(
   parameter int  WIDTH = 1,
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta   <= {WIDTH{RST_VAL}};
         sync_o <= {WIDTH{RST_VAL}};
      end
      else
      begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// ### hdl/hsc_crc8.sv
// one-byte step of the checksum generator
`timescale 1ns/1ps
module hsc_crc8
   import hsc_pkg::*;
(
   input  wire logic [7:0] crc_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] crc_o
);
   always_comb
   begin
      logic [7:0] c;
      c = crc_i ^ data_i;
      for (int i = 0; i < 8; i++)
      begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      crc_o = c;
   end
endmodule

// ### hdl/hsc_top.sv
// humidity sensor serial command port and mode front end
//
// Overview of operation
// - mode pins pick analogue, pulse or serial
// - pulse modes drive SDA low while pulse_level_i is low
// - idle reached after 10 ms of SCL high from power-up
// - unused sensor falls back to sleep
// - detect start and stop conditions
// - answer only target address 1000000
// - pull SDA low for acknowledge bit
// - E3/E5 start hold-mode measurements
// - F3/F5 measure with SCL released
// - hold SCL low during hold conversion
// - poll read acknowledged only when ready
// - result bit 1 is type, bit 0 zero
// - master NACK after LSB skips checksum
// - conversion times by type and resolution
// - accept repeated start or stop
// - sample on SCL rise, change after fall
// - both lines open-drain, pull low only
// - static logic, no minimum SCL rate
// - checksum is CRC-8, x^8+x^5+x^4+1
// - soft reset restores defaults, except user_reg bit 2, within 15 ms
// - defaults 12/14 bit, MSB first bytes
`timescale 1ns/1ps
module hsc_top
   import hsc_pkg::*;
#(
   parameter int STARTUP_CYCLES    = STARTUP_CYC,
   parameter int SOFT_RESET_CYCLES = SOFT_RESET_CYC,
   parameter int CYCLES_PER_MS     = CYC_PER_MS
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [1:0]  mode_sel_i,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic [13:0] temp_sample_i,
   input  wire logic [13:0] hum_sample_i,
   input  wire logic        pulse_level_i,
   output logic             humidity_voltage_out,
   output logic             analog_en_o,
   output logic             sleep_o,
   output logic             meas_busy_o,
   output logic [15:0]      humidity_result_word,
   output logic [7:0]       user_reg_o
);
   import hsc_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [1:0] sync_lines;
   logic [1:0] mode_s;
   logic       scl_d;
   logic       sda_d;

   hsc_sync #(.WIDTH(2), .RST_VAL(1'b1)) u_sync_bus (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    (sync_lines)
   );

   hsc_sync #(.WIDTH(2), .RST_VAL(1'b0)) u_sync_mode (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (mode_sel_i),
      .sync_o    (mode_s)
   );

   wire scl_s    = sync_lines[1];
   wire sda_s    = sync_lines[0];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   // edges found by oversampling, so any slow SCL works
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // ------------------------------------------------------------
   // mode decode and startup timer
   // ------------------------------------------------------------
   logic [31:0] boot_cnt;
   logic        ready;
   wire         i2c_mode   = (mode_s == MODE_I2C);
   wire         pulse_mode = (mode_s == MODE_PWM) || (mode_s == MODE_PDM);
   wire         boot_done  = (boot_cnt == 32'h0);
   logic        soft_rst_req;

   // idle is reached once the count expires; a soft reset reloads it
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         boot_cnt <= STARTUP_CYCLES[31:0];
      else if (soft_rst_req)
         boot_cnt <= SOFT_RESET_CYCLES[31:0];
      else if (!boot_done && scl_s)
         boot_cnt <= boot_cnt - 32'h1;
   end
   assign ready = boot_done;

   // ------------------------------------------------------------
   // measurement engine
   // ------------------------------------------------------------
   logic [7:0]  user_reg;
   logic        meas_hum;
   logic        meas_busy;
   logic        result_ok;
   logic [31:0] meas_cnt;
   logic [15:0] result;
   logic        meas_go;
   logic        meas_go_hum;
   wire  [1:0]  res_sel = {user_reg[7], user_reg[0]};
   logic [31:0] meas_ms;

   // conversion time from type and resolution
   always_comb
   begin
      unique case (res_sel)
         2'b00:   meas_ms = meas_go_hum ? RH12_MS : T14_MS;
         2'b01:   meas_ms = meas_go_hum ? RH8_MS  : T13_MS;
         2'b10:   meas_ms = meas_go_hum ? RH11_MS : T13_MS;
         default: meas_ms = meas_go_hum ? RH11_MS : T11_MS;
      endcase
   end

   wire [31:0] meas_load = meas_ms * CYCLES_PER_MS;
   wire [15:0] next_result = meas_hum ? {hum_sample_i, 2'b10} : {temp_sample_i, 2'b00};

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meas_busy <= 1'b0;
         meas_hum  <= 1'b0;
         meas_cnt  <= 32'h0;
         result_ok <= 1'b0;
         result    <= 16'h0;
      end
      else if (meas_go)
      begin
         meas_busy <= 1'b1;
         meas_hum  <= meas_go_hum;
         meas_cnt  <= meas_load;
         result_ok <= 1'b0;
      end
      else if (meas_busy)
      begin
         if (meas_cnt <= 32'h1)
         begin
            meas_busy <= 1'b0;
            result_ok <= 1'b1;
            result    <= next_result;
         end
         else
            meas_cnt <= meas_cnt - 32'h1;
      end
   end

   // ------------------------------------------------------------
   // serial target state machine
   // ------------------------------------------------------------
   typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA, ST_WDATA_ACK,
                 ST_HOLD, ST_TX, ST_TX_ACK, ST_IGNORE} hsc_state_e;
   hsc_state_e  state;
   logic [7:0]  shreg;
   logic [3:0]  bitcnt;
   logic [7:0]  cmd;
   logic [1:0]  byte_idx;
   logic [7:0]  crc;
   logic        sda_low;
   logic        scl_low;
   logic        hold_pend;
   logic [7:0]  crc_next;

   hsc_crc8 u_crc (
      .crc_i  (crc),
      .data_i (shreg),
      .crc_o  (crc_next)
   );

   wire [7:0] rx_byte   = {shreg[6:0], sda_s};
   wire       addr_hit  = (rx_byte[7:1] == DEV_ADDR);
   wire       is_hold   = (rx_byte == CMD_T_HOLD) || (rx_byte == CMD_RH_HOLD);
   wire       is_poll   = (rx_byte == CMD_T_POLL) || (rx_byte == CMD_RH_POLL);
   wire       rd_ready  = result_ok && !meas_busy;
   wire       rd_user   = (cmd == CMD_RD_USER);

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state        <= ST_IDLE;
         shreg        <= 8'h0;
         bitcnt       <= 4'h0;
         cmd          <= 8'h0;
         byte_idx     <= 2'd0;
         crc          <= CRC_INIT;
         sda_low      <= 1'b0;
         scl_low      <= 1'b0;
         hold_pend    <= 1'b0;
         user_reg     <= USER_RESET;
         meas_go      <= 1'b0;
         meas_go_hum  <= 1'b0;
         soft_rst_req <= 1'b0;
      end
      else
      begin
         meas_go      <= 1'b0;
         soft_rst_req <= 1'b0;
         if (!i2c_mode || !ready)
         begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
            scl_low <= 1'b0;
         end
         else if (stop_c)
         begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
         end
         else if (start_c)
         begin
            state   <= ST_ADDR;
            bitcnt  <= 4'h0;
            sda_low <= 1'b0;
         end
         else
         begin
            unique case (state)
               ST_IDLE, ST_IGNORE: sda_low <= 1'b0;
               ST_ADDR, ST_CMD, ST_WDATA:
                  if (scl_rise)
                  begin
                     shreg  <= rx_byte;
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt == 4'd7)
                     begin
                        if (state == ST_ADDR)
                        begin
                           if (addr_hit && (!rx_byte[0] || rd_ready || rd_user))
                              state <= ST_ADDR_ACK;
                           else
                              state <= ST_IGNORE;
                        end
                        else if (state == ST_CMD)
                        begin
                           cmd   <= rx_byte;
                           state <= ST_CMD_ACK;
                           if (is_hold || is_poll)
                           begin
                              meas_go     <= 1'b1;
                              meas_go_hum <= rx_byte[2];
                              hold_pend   <= is_hold;
                           end
                        end
                        else
                        begin
                           user_reg <= rx_byte;
                           state    <= ST_WDATA_ACK;
                        end
                     end
                  end
               ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK:
                  if (scl_fall)
                  begin
                     if (!sda_low)
                        sda_low <= 1'b1;
                     else
                     begin
                        sda_low <= 1'b0;
                        bitcnt  <= 4'h0;
                        if (state == ST_ADDR_ACK && shreg[0])
                        begin
                           state    <= ST_TX;
                           byte_idx <= 2'd0;
                           crc      <= CRC_INIT;
                           shreg    <= rd_user ? user_reg : result[15:8];
                           sda_low  <= rd_user ? ~user_reg[7] : ~result[15];
                        end
                        else if (state == ST_ADDR_ACK)
                           state <= ST_CMD;
                        else if (state == ST_CMD_ACK && cmd == CMD_SOFT_RST)
                        begin
                           // reset only once the command byte has been acknowledged
                           soft_rst_req <= 1'b1;
                           user_reg     <= {USER_RESET[7:3], user_reg[2], USER_RESET[1:0]};
                           state        <= ST_IGNORE;
                        end
                        else if (state == ST_CMD_ACK && cmd == CMD_WR_USER)
                           state <= ST_WDATA;
                        else if (state == ST_CMD_ACK && hold_pend)
                        begin
                           state   <= ST_HOLD;
                           scl_low <= 1'b1;
                        end
                        else
                           state <= ST_IGNORE;
                     end
                  end
               ST_HOLD:
                  if (!meas_busy && !meas_go)
                  begin
                     scl_low   <= 1'b0;
                     hold_pend <= 1'b0;
                     state     <= ST_IGNORE;
                  end
               ST_TX:
                  if (scl_fall)
                  begin
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt == 4'd7)
                     begin
                        sda_low <= 1'b0;
                        state   <= ST_TX_ACK;
                     end
                     else
                        sda_low <= ~shreg[6 - bitcnt[2:0]];
                  end
               ST_TX_ACK:
                  if (scl_rise)
                  begin
                     crc <= crc_next;
                     if (sda_s || rd_user || byte_idx == 2'd2)
                        state <= ST_IGNORE;
                  end
                  else if (scl_fall)
                  begin
                     byte_idx <= byte_idx + 2'd1;
                     bitcnt   <= 4'h0;
                     shreg    <= (byte_idx == 2'd0) ? result[7:0] : crc;
                     sda_low  <= (byte_idx == 2'd0) ? ~result[7] : ~crc[7];
                     state    <= ST_TX;
                  end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // pin drivers and status
   // ------------------------------------------------------------
   // open-drain: data is always 0, only the enable moves
   wire pulse_drive = pulse_mode && ready && !pulse_level_i;
   assign sda_o    = 1'b0;
   assign scl_o    = 1'b0;
   assign sda_oe_o = i2c_mode ? sda_low : pulse_drive;
   assign scl_oe_o = i2c_mode & scl_low;

   // analogue path only in mode 00, scl high host side fixes SCL
   assign analog_en_o          = (mode_s == MODE_ANALOG) && ready;
   assign humidity_voltage_out = analog_en_o & pulse_level_i;
   // sleep after startup whenever nothing is measured or talked
   assign sleep_o              = ready && !meas_busy && (state == ST_IDLE);
   assign meas_busy_o          = meas_busy;
   assign humidity_result_word = result;
   assign user_reg_o           = user_reg;
endmodule

// ### sim/hsc_top_sva.sv
// assertion checker for the humidity sensor command port
`timescale 1ns/1ps
module hsc_top_sva
   import hsc_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYC_PER_MS
) (
   input wire logic        sys_clk_i,
   input wire logic        reset_n_i,
   input wire logic [1:0]  mode_sel_i,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe_o,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic [13:0] temp_sample_i,
   input wire logic [13:0] hum_sample_i,
   input wire logic        pulse_level_i,
   input wire logic        humidity_voltage_out,
   input wire logic        analog_en_o,
   input wire logic        sleep_o,
   input wire logic        meas_busy_o,
   input wire logic [15:0] humidity_result_word,
   input wire logic [7:0]  user_reg_o
);
   // slack of a few cycles covers the pin synchronisers
   localparam int LO   = T11_MS * CYCLES_PER_MS - 10;
   localparam int SPAN = (RH12_MS - T11_MS) * CYCLES_PER_MS + 20;
   wire logic     pulse_mode = (mode_sel_i == MODE_PWM) || (mode_sel_i == MODE_PDM);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ---------
   // properties
   // ---------
   chk_lines_low_only: assert property (!scl_o && !sda_o)
      else $error("bus line driven high");
   chk_release_on_done: assert property ($fell(meas_busy_o) |-> ##[0:3] !scl_oe_o)
      else $error("clock still stretched after conversion");
   chk_stretch_bound: assert property ($rose(scl_oe_o) |->
      (scl_oe_o throughout ##LO 1) ##[1:SPAN] !scl_oe_o)
      else $error("stretch length outside conversion time");
   chk_pulse_low_pulls: assert property ((pulse_mode && !pulse_level_i)[*5] |-> sda_oe_o)
      else $error("pulse low not on data line");
   chk_pulse_high_frees: assert property ((pulse_mode && pulse_level_i)[*5] |-> !sda_oe_o)
      else $error("pulse high not on data line");
   chk_analog_off: assert property ((mode_sel_i != MODE_ANALOG)[*5] |-> !analog_en_o)
      else $error("analogue output on in wrong mode");
   chk_hvout_gated: assert property (humidity_voltage_out |-> analog_en_o)
      else $error("voltage output active while disabled");
   chk_busy_awake: assert property (meas_busy_o [*2] |-> !sleep_o)
      else $error("asleep while measuring");
   chk_result_status: assert property ($changed(humidity_result_word) &&
      humidity_result_word != 16'h0000 |-> !humidity_result_word[0] &&
      humidity_result_word[15:2] == (humidity_result_word[1] ? hum_sample_i : temp_sample_i))
      else $error("result word does not match sample and type");
   chk_sda_scl_low: assert property ((mode_sel_i == MODE_I2C)[*5] ##0
      $changed(sda_oe_o) |-> !scl_i)
      else $error("data changed while clock high");
   cover property ($rose(scl_oe_o));
   cover property (meas_busy_o && !scl_oe_o);
   cover property ($rose(analog_en_o));
endmodule

bind hsc_top hsc_top_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_hsc_top_sva (
   .sys_clk_i, .reset_n_i, .mode_sel_i, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o,
   .sda_oe_o, .temp_sample_i, .hum_sample_i, .pulse_level_i, .humidity_voltage_out,
   .analog_en_o, .sleep_o, .meas_busy_o, .humidity_result_word, .user_reg_o);

// ### sim/hsc_i2c_master.sv
// behavioural two-wire bus master facing the sensor port
`timescale 1ns/1ps
module hsc_i2c_master (
   input  wire logic sys_clk_i,
   input  wire logic link_clk_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_pull_o,
   output logic      sda_pull_o,
   output logic      res_v_o,
   output logic [8:0] res_d_o
);
   initial
   begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
      res_v_o    = 1'b0;
      res_d_o    = 9'h000;
   end
   // ---------
   // bus phases: one quarter bit per link clock period
   // ---------
   task automatic step();
      @(posedge link_clk_i);
      @(posedge sys_clk_i);
   endtask
   // bounded so a stuck line costs time, not the run
   task automatic scl_up();
      int n;
      n = 0;
      scl_pull_o <= 1'b0;
      step();
      while (scl_i !== 1'b1 && n < 4000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
   endtask
   task automatic start();
      sda_pull_o <= 1'b0;
      step();
      scl_up();
      step();
      sda_pull_o <= 1'b1;
      step();
      scl_pull_o <= 1'b1;
      step();
   endtask
   task automatic stop();
      sda_pull_o <= 1'b1;
      step();
      scl_up();
      step();
      sda_pull_o <= 1'b0;
      step();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_pull_o <= !b;
      step();
      scl_up();
      step();
      r = sda_i;
      scl_pull_o <= 1'b1;
      step();
   endtask
   task automatic xbyte(input logic [7:0] d, input logic ab);
      logic [7:0] r;
      logic       a;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(ab, a);
      res_d_o <= {r, a};
      res_v_o <= 1'b1;
      @(posedge sys_clk_i);
      res_v_o <= 1'b0;
   endtask
   task automatic hold_scl(input logic lvl);
      scl_pull_o <= !lvl;
   endtask
endmodule

// ### sim/hsc_top_tb.sv
// self-checking bench for the humidity sensor command port
`timescale 1ns/1ps
module hsc_top_tb;
   import hsc_pkg::*;
   localparam int STARTUP  = 20;
   localparam int SOFT_RST = 30;
   localparam int CPM      = 20;
   logic        sys_clk     = 1'b0;
   logic        link_clk    = 1'b0;
   logic        reset_n     = 1'b0;
   logic [1:0]  mode_sel    = MODE_I2C;
   logic [13:0] temp_sample = 14'h0000;
   logic [13:0] hum_sample  = 14'h0000;
   logic        pulse_level = 1'b1;
   logic        m_scl, m_sda, res_v, scl_oe, sda_oe, analog_en, sleep, hvout;
   logic [15:0] result_word;
   logic [8:0]  res_d;
   logic [7:0]  user_reg;
   wire logic   scl_line = !(m_scl || scl_oe);
   wire logic   sda_line = !(m_sda || sda_oe);
   logic [8:0]  exp_q[$];
   int          fail_count  = 0;
   int          checks_done = 0;
   int          seed        = 32'h890A;
   logic [7:0]  cmds[4]     = '{CMD_T_HOLD, CMD_RH_HOLD, CMD_T_POLL, CMD_RH_POLL};

   always #2.5 sys_clk = ~sys_clk;
   initial
   begin
      #7;
      forever #24 link_clk = ~link_clk;
   end

   hsc_top #(.STARTUP_CYCLES(STARTUP), .SOFT_RESET_CYCLES(SOFT_RST), .CYCLES_PER_MS(CPM))
   i_hsc_top (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .mode_sel_i(mode_sel),
      .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(),
      .sda_oe_o(sda_oe), .temp_sample_i(temp_sample), .hum_sample_i(hum_sample),
      .pulse_level_i(pulse_level), .humidity_voltage_out(hvout), .analog_en_o(analog_en),
      .sleep_o(sleep), .meas_busy_o(), .humidity_result_word(result_word),
      .user_reg_o(user_reg));
   hsc_i2c_master i_hsc_i2c_master (.sys_clk_i(sys_clk), .link_clk_i(link_clk),
      .scl_i(scl_line), .sda_i(sda_line), .scl_pull_o(m_scl), .sda_pull_o(m_sda),
      .res_v_o(res_v), .res_d_o(res_d));
   // ---------
   // helpers
   // ---------
   task automatic print_verdict();
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      checks_done++;
      if (seen !== want)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 15; i >= 0; i--)
         c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      return c;
   endfunction
   task automatic wr(input logic [7:0] d);
      exp_q.push_back({d, 1'b0});
      i_hsc_i2c_master.xbyte(d, 1'b1);
   endtask
   task automatic rd(input logic [7:0] d, input logic ab);
      exp_q.push_back({d, ab});
      i_hsc_i2c_master.xbyte(8'hFF, ab);
   endtask
   task automatic rd_user(input logic [7:0] v);
      i_hsc_i2c_master.start();
      wr({DEV_ADDR, 1'b0});
      wr(CMD_RD_USER);
      i_hsc_i2c_master.start();
      wr({DEV_ADDR, 1'b1});
      rd(v, 1'b1);
      i_hsc_i2c_master.stop();
   endtask
   always @(posedge sys_clk)
      if (res_v === 1'b1)
         check(res_d, exp_q.size() > 0 ? exp_q.pop_front() : ~res_d);
   // run takes some 17000 cycles; the limit leaves wide margin
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end
   // ---------
   // main sequence
   // ---------
   initial
   begin
      logic [7:0]  cmd, crc, bad;
      logic [15:0] word;
      logic        hum;
      logic [13:0] ts, hs;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (STARTUP + 10) @(posedge sys_clk);
      check({8'h00, sleep}, 9'h001);
      bad = {DEV_ADDR ^ (7'($random(seed)) | 7'h01), 1'b0};
      i_hsc_i2c_master.start();
      exp_q.push_back({bad, 1'b1});
      i_hsc_i2c_master.xbyte(bad, 1'b1);
      i_hsc_i2c_master.stop();
      for (int k = 0; k < 4; k++)
      begin
         cmd = cmds[k];
         hum = cmd[2];
         ts = 14'($random(seed));
         hs = {12'($random(seed)), 2'b00};
         temp_sample <= ts;
         hum_sample <= hs;
         word = hum ? {hs, 2'b10} : {ts, 2'b00};
         crc = crc8(word);
         i_hsc_i2c_master.start();
         wr({DEV_ADDR, 1'b0});
         wr(cmd);
         if (cmd[4])
         begin
            i_hsc_i2c_master.start();
            exp_q.push_back({DEV_ADDR, 1'b1, 1'b1});
            i_hsc_i2c_master.xbyte({DEV_ADDR, 1'b1}, 1'b1);
            check({8'h00, scl_oe}, 9'h000);
            i_hsc_i2c_master.stop();
            repeat (RH12_MS * CPM) @(posedge sys_clk);
         end
         i_hsc_i2c_master.start();
         wr({DEV_ADDR, 1'b1});
         rd(word[15:8], 1'b0);
         rd(word[7:0], hum);
         if (!hum)
            rd(crc, 1'b1);
         i_hsc_i2c_master.stop();
      end
      check({1'b0, result_word[15:8]}, {1'b0, word[15:8]});
      check({1'b0, result_word[7:0]}, {1'b0, word[7:0]});
      i_hsc_i2c_master.start();
      wr({DEV_ADDR, 1'b0});
      wr(CMD_WR_USER);
      wr(USER_RESET | 8'h01);
      i_hsc_i2c_master.stop();
      rd_user(USER_RESET | 8'h01);
      check({1'b0, user_reg}, {1'b0, USER_RESET | 8'h01});
      i_hsc_i2c_master.start();
      wr({DEV_ADDR, 1'b0});
      wr(CMD_SOFT_RST);
      i_hsc_i2c_master.stop();
      repeat (SOFT_RST + STARTUP + 10) @(posedge sys_clk);
      rd_user(USER_RESET);
      for (int m = 1; m < 3; m++)
      begin
         mode_sel <= 2'(m);
         i_hsc_i2c_master.hold_scl(m[0]);
         for (int k = 0; k < 120; k++)
         begin
            @(posedge sys_clk);
            if (k % 6 == 0)
               pulse_level <= 1'($random(seed));
         end
         check({8'h00, analog_en}, 9'h000);
      end
      mode_sel <= MODE_ANALOG;
      pulse_level <= 1'b1;
      i_hsc_i2c_master.hold_scl(1'b1);
      repeat (20) @(posedge sys_clk);
      check({8'h00, analog_en}, 9'h001);
      check({8'h00, hvout}, 9'h001);
      repeat (5) @(posedge sys_clk);
      check(9'(exp_q.size()), 9'h000);
      print_verdict();
   end
endmodule
